// file: core/frc_map.svh
// frc_map.svh: address map, field positions, codes and timing defaults of the flash rewrite sequencer
// assumes: included by bare name from the sequencer and the simulation files; the package and the op timer do not include it
`ifndef FRC_MAP_SVH
`define FRC_MAP_SVH

// ----------------------------------------
// bus and register map
// ----------------------------------------
`define FRC_ADDR_W 12
`define FRC_FLASH_SEL_BIT 11
`define FRC_REG_A_ADDR 12'h0000
`define FRC_REG_B_ADDR 12'h0004
`define FRC_REG_A_RESET 8'h01
`define FRC_REG_B_RESET 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define FRC_A_READY 0
`define FRC_A_RW_EN 1
`define FRC_A_LOCK_DIS 2
`define FRC_A_PRG_ERR 6
`define FRC_A_ERS_ERR 7
`define FRC_B_HALT 1
`define FRC_B_LOCK_ST 6
`define FRC_SR_READY 7
`define FRC_SR_ERS 5
`define FRC_SR_PRG 4

// ----------------------------------------
// command codes (low byte only)
// ----------------------------------------
`define FRC_CMD_READ_ARRAY 8'hFF
`define FRC_CMD_READ_STATUS 8'h70
`define FRC_CMD_CLEAR_STATUS 8'h50
`define FRC_CMD_PROGRAM 8'h40
`define FRC_CMD_ERASE 8'h20
`define FRC_CMD_LOCK_PROG 8'h77
`define FRC_CMD_READ_LOCK 8'h71
`define FRC_CMD_CONFIRM 8'hD0

// ----------------------------------------
// storage and timing defaults
// ----------------------------------------
`define FRC_ERASED_WORD 16'hFFFF
`define FRC_MEM_WORDS 64
`define FRC_BLOCK_WORDS 16
`define FRC_PROG_CYCLES 64
`define FRC_ERASE_CYCLES 256
`define FRC_LOCK_CYCLES 32
`define FRC_RLS_CYCLES 4

`endif

// file: core/frc_pkg.sv
// frc_pkg: types shared by the flash rewrite sequencer
// assumes: nothing beyond the map header
package frc_pkg;

   // ----------------------------------------
   // command sequencer states
   // ----------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_PROG2 = 6'b00_0010,
      ST_ERASE2 = 6'b00_0100,
      ST_LOCK2 = 6'b00_1000,
      ST_RLS2 = 6'b01_0000,
      ST_BUSY = 6'b10_0000
   } frc_state_t;

   // ----------------------------------------
   // running automatic operation
   // ----------------------------------------
   typedef enum logic [1:0] {
      OP_PROG = 2'h0,
      OP_ERASE = 2'h1,
      OP_LOCK = 2'h2,
      OP_RLS = 2'h3
   } frc_op_t;

endpackage : frc_pkg

// file: core/frc_op_timer.sv
// frc_op_timer: down counter that times one automatic flash operation
// assumes: start and abort are one-cycle pulses from the sequencer
`timescale 1ns/1ps

module frc_op_timer #(
   parameter int CW = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic start,
   input wire logic abort,
   input wire logic [CW-1:0] load,
   // result
   output logic done,
   output logic running
);

   logic [CW-1:0] cnt_r, cnt_nxt;
   logic run_r, run_nxt;
   logic done_r, done_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      done_nxt = 1'b0;
      if (abort) begin
         cnt_nxt = '0;
         run_nxt = 1'b0;
      end else if (start) begin
         // a zero load still takes one cycle
         cnt_nxt = (load == '0) ? CW'(1) : load;
         run_nxt = 1'b1;
      end else if (run_r) begin
         if (cnt_r == CW'(1)) begin
            run_nxt = 1'b0;
            done_nxt = 1'b1;
         end
         cnt_nxt = cnt_r - CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;
   assign running = run_r;

endmodule : frc_op_timer

// file: core/frc_sequencer.sv
// frc_sequencer: command sequencer for on-chip flash in cpu rewrite mode, with its control registers
// assumes: avalon-mm master with waitrequest; flash user area is the upper half of the address space,
// one 16-bit flash word per 32-bit bus word in the low lanes
`timescale 1ns/1ps
`include "frc_map.svh"

module frc_sequencer #(
   parameter int MEM_WORDS = `FRC_MEM_WORDS,
   parameter int BLOCK_WORDS = `FRC_BLOCK_WORDS,
   parameter int OP_CW = 16,
   parameter int PROG_CYCLES = `FRC_PROG_CYCLES,
   parameter int ERASE_CYCLES = `FRC_ERASE_CYCLES,
   parameter int LOCK_CYCLES = `FRC_LOCK_CYCLES,
   parameter int RLS_CYCLES = `FRC_RLS_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [`FRC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // forced-reset events, one-cycle pulses
   input wire logic nmi_event,
   input wire logic watchdog_event
);

   localparam int IW = $clog2(MEM_WORDS);
   localparam int BW = $clog2(BLOCK_WORDS);
   localparam int NBLK = MEM_WORDS / BLOCK_WORDS;

   // ----------------------------------------
   // state
   // ----------------------------------------
   frc_pkg::frc_state_t st_r, st_nxt;
   frc_pkg::frc_op_t op_r, op_nxt;
   logic [IW-1:0] op_idx_r, op_idx_nxt;
   logic [15:0] op_data_r, op_data_nxt;
   logic [15:0] mem_r [MEM_WORDS];
   logic [15:0] mem_nxt [MEM_WORDS];
   logic [NBLK-1:0] unlocked_r, unlocked_nxt;
   logic rw_en_r, rw_en_nxt;
   logic lock_dis_r, lock_dis_nxt;
   logic prg_err_r, prg_err_nxt;
   logic ers_err_r, ers_err_nxt;
   logic halt_r, halt_nxt;
   logic lock_st_r, lock_st_nxt;
   logic stat_mode_r, stat_mode_nxt;
   logic wait_r, wait_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic req, acc, wr_acc, is_flash, stall, busy, forced, t_start, t_done;
   logic [IW-1:0] fidx;
   logic [7:0] cmd;
   logic [7:0] status_val, reg_a_val, reg_b_val;
   logic [OP_CW-1:0] t_load;
   logic [NBLK-1:0] blk_prot;
   logic [IW-BW-1:0] op_blk;
   logic top_of_blk, err_any;

   assign req = avs_read || avs_write;
   assign acc = req && !wait_r;
   assign wr_acc = acc && avs_write && avs_byteenable[0];
   assign is_flash = avs_address[`FRC_FLASH_SEL_BIT];
   assign fidx = avs_address[IW+1:2];
   assign cmd = avs_writedata[7:0];
   assign busy = (st_r == frc_pkg::ST_BUSY);
   assign top_of_blk = (fidx[BW-1:0] == {BW{1'b1}});
   assign op_blk = op_idx_r[IW-1:BW];
   assign err_any = prg_err_r || ers_err_r;
   // halting mode holds the cpu on flash access until the operation ends
   assign stall = is_flash && halt_r && busy;
   // watchdog only forces reset in the cpu-running mode
   assign forced = nmi_event || (watchdog_event && !halt_r);

   genvar b;
   generate
      for (b = 0; b < NBLK; b++) begin : g_prot
         assign blk_prot[b] = !unlocked_r[b] && !lock_dis_r;
      end
   endgenerate

   always_comb begin
      status_val = 8'h00;
      status_val[`FRC_SR_READY] = !busy;
      status_val[`FRC_SR_ERS] = ers_err_r;
      status_val[`FRC_SR_PRG] = prg_err_r;
      reg_a_val = 8'h00;
      reg_a_val[`FRC_A_READY] = !busy;
      reg_a_val[`FRC_A_RW_EN] = rw_en_r;
      reg_a_val[`FRC_A_LOCK_DIS] = lock_dis_r;
      reg_a_val[`FRC_A_PRG_ERR] = prg_err_r;
      reg_a_val[`FRC_A_ERS_ERR] = ers_err_r;
      reg_b_val = 8'h00;
      reg_b_val[`FRC_B_HALT] = halt_r;
      reg_b_val[`FRC_B_LOCK_ST] = lock_st_r;
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   always_comb begin
      wait_nxt = !(req && wait_r && !stall);
      rdata_nxt = rdata_r;
      // only a read answer moves the read data, so writes leave it standing
      if (avs_read && wait_r && !stall) begin
         if (is_flash) begin
            if (stat_mode_r && rw_en_r) begin
               rdata_nxt = {24'h00_0000, status_val};
            end else begin
               rdata_nxt = {16'h0000, mem_r[fidx]};
            end
         end else if (avs_address == `FRC_REG_A_ADDR) begin
            rdata_nxt = {24'h00_0000, reg_a_val};
         end else if (avs_address == `FRC_REG_B_ADDR) begin
            rdata_nxt = {24'h00_0000, reg_b_val};
         end else begin
            rdata_nxt = 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------
   // command sequencer
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      op_idx_nxt = op_idx_r;
      op_data_nxt = op_data_r;
      mem_nxt = mem_r;
      unlocked_nxt = unlocked_r;
      rw_en_nxt = rw_en_r;
      lock_dis_nxt = lock_dis_r;
      prg_err_nxt = prg_err_r;
      ers_err_nxt = ers_err_r;
      halt_nxt = halt_r;
      lock_st_nxt = lock_st_r;
      stat_mode_nxt = stat_mode_r;
      t_start = 1'b0;
      t_load = '0;
      // software writes to the control registers
      if (wr_acc && !is_flash) begin
         if (avs_address == `FRC_REG_A_ADDR) begin
            rw_en_nxt = avs_writedata[`FRC_A_RW_EN];
            lock_dis_nxt = avs_writedata[`FRC_A_LOCK_DIS];
         end else if (avs_address == `FRC_REG_B_ADDR) begin
            halt_nxt = avs_writedata[`FRC_B_HALT];
         end
      end
      // flash-area writes are commands only with rewrite enabled and not busy
      if (wr_acc && is_flash && rw_en_r && !busy) begin
         case (st_r)
            frc_pkg::ST_IDLE: begin
               case (cmd)
                  `FRC_CMD_READ_ARRAY: stat_mode_nxt = 1'b0;
                  `FRC_CMD_READ_STATUS: stat_mode_nxt = 1'b1;
                  `FRC_CMD_CLEAR_STATUS: begin
                     prg_err_nxt = 1'b0;
                     ers_err_nxt = 1'b0;
                  end
                  `FRC_CMD_PROGRAM: begin
                     if (!err_any) begin
                        st_nxt = frc_pkg::ST_PROG2;
                     end
                  end
                  `FRC_CMD_ERASE: begin
                     if (!err_any) begin
                        st_nxt = frc_pkg::ST_ERASE2;
                     end
                  end
                  `FRC_CMD_LOCK_PROG: begin
                     if (!err_any) begin
                        st_nxt = frc_pkg::ST_LOCK2;
                     end
                  end
                  `FRC_CMD_READ_LOCK: begin
                     stat_mode_nxt = 1'b0;
                     st_nxt = frc_pkg::ST_RLS2;
                  end
                  default: begin
                  end
               endcase
            end
            frc_pkg::ST_PROG2: begin
               // the whole word is data here
               op_nxt = frc_pkg::OP_PROG;
               op_idx_nxt = fidx;
               op_data_nxt = avs_writedata[15:0];
               t_load = OP_CW'(PROG_CYCLES);
               t_start = 1'b1;
               st_nxt = frc_pkg::ST_BUSY;
               if (!halt_r) begin
                  stat_mode_nxt = 1'b1;
               end
            end
            frc_pkg::ST_ERASE2, frc_pkg::ST_LOCK2, frc_pkg::ST_RLS2: begin
               if (cmd == `FRC_CMD_CONFIRM) begin
                  op_idx_nxt = fidx;
                  st_nxt = frc_pkg::ST_BUSY;
                  t_start = 1'b1;
                  if (st_r == frc_pkg::ST_ERASE2) begin
                     op_nxt = frc_pkg::OP_ERASE;
                     t_load = OP_CW'(ERASE_CYCLES);
                  end else if (st_r == frc_pkg::ST_LOCK2) begin
                     op_nxt = frc_pkg::OP_LOCK;
                     t_load = OP_CW'(LOCK_CYCLES);
                  end else begin
                     op_nxt = frc_pkg::OP_RLS;
                     t_load = OP_CW'(RLS_CYCLES);
                  end
                  if (!halt_r && st_r != frc_pkg::ST_RLS2) begin
                     stat_mode_nxt = 1'b1;
                  end
                  // confirm off the block top is a misuse; treat as sequence error
                  if (!top_of_blk) begin
                     st_nxt = frc_pkg::ST_IDLE;
                     t_start = 1'b0;
                     prg_err_nxt = 1'b1;
                     ers_err_nxt = 1'b1;
                  end
               end else if (cmd == `FRC_CMD_READ_ARRAY) begin
                  st_nxt = frc_pkg::ST_IDLE;
                  stat_mode_nxt = 1'b0;
               end else begin
                  st_nxt = frc_pkg::ST_IDLE;
                  if (st_r != frc_pkg::ST_RLS2) begin
                     prg_err_nxt = 1'b1;
                     ers_err_nxt = 1'b1;
                  end
               end
            end
            default: st_nxt = frc_pkg::ST_IDLE;
         endcase
      end
      // completion of the automatic operation
      if (busy && t_done) begin
         st_nxt = frc_pkg::ST_IDLE;
         if (halt_r) begin
            stat_mode_nxt = 1'b0;
         end
         case (op_r)
            frc_pkg::OP_PROG: begin
               // a program can only clear bits, so data that needs an already cleared bit set fails verify
               if (blk_prot[op_blk] || ((mem_r[op_idx_r] & op_data_r) != op_data_r)) begin
                  prg_err_nxt = 1'b1;
               end
               if (!blk_prot[op_blk]) begin
                  mem_nxt[op_idx_r] = mem_r[op_idx_r] & op_data_r;
               end
            end
            frc_pkg::OP_ERASE: begin
               if (blk_prot[op_blk]) begin
                  ers_err_nxt = 1'b1;
               end else begin
                  for (int i = 0; i < MEM_WORDS; i++) begin
                     if (i / BLOCK_WORDS == int'(op_blk)) begin
                        mem_nxt[i] = `FRC_ERASED_WORD;
                     end
                  end
                  unlocked_nxt[op_blk] = 1'b1;
               end
            end
            frc_pkg::OP_LOCK: unlocked_nxt[op_blk] = 1'b0;
            frc_pkg::OP_RLS: lock_st_nxt = unlocked_r[op_blk];
            default: begin
            end
         endcase
      end
      // forced reset of both control registers wins over writes and commands; an ending operation still updates the array and lock bits
      if (forced) begin
         st_nxt = frc_pkg::ST_IDLE;
         rw_en_nxt = 1'(`FRC_REG_A_RESET >> `FRC_A_RW_EN);
         lock_dis_nxt = 1'b0;
         prg_err_nxt = 1'b0;
         ers_err_nxt = 1'b0;
         halt_nxt = 1'b0;
         lock_st_nxt = 1'b0;
         stat_mode_nxt = 1'b0;
         t_start = 1'b0;
      end
   end

   frc_op_timer #(
      .CW(OP_CW)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .start(t_start),
      .abort(forced),
      .load(t_load),
      .done(t_done),
      .running()
   );

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= frc_pkg::ST_IDLE;
         op_r <= frc_pkg::OP_PROG;
         op_idx_r <= '0;
         op_data_r <= 16'h0000;
         unlocked_r <= '1;
         rw_en_r <= 1'b0;
         lock_dis_r <= 1'b0;
         prg_err_r <= 1'b0;
         ers_err_r <= 1'b0;
         halt_r <= 1'b0;
         lock_st_r <= 1'b0;
         stat_mode_r <= 1'b0;
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
         for (int i = 0; i < MEM_WORDS; i++) begin
            mem_r[i] <= `FRC_ERASED_WORD;
         end
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         op_idx_r <= op_idx_nxt;
         op_data_r <= op_data_nxt;
         unlocked_r <= unlocked_nxt;
         rw_en_r <= rw_en_nxt;
         lock_dis_r <= lock_dis_nxt;
         prg_err_r <= prg_err_nxt;
         ers_err_r <= ers_err_nxt;
         halt_r <= halt_nxt;
         lock_st_r <= lock_st_nxt;
         stat_mode_r <= stat_mode_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         mem_r <= mem_nxt;
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;

endmodule : frc_sequencer

// file: sim/frc_sequencer_properties.sv
// frc_sequencer_properties: port-level assertions on the flash rewrite sequencer
// assumes: bound onto frc_sequencer from tb_top; one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "frc_map.svh"
module frc_sequencer_properties (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave side
   input wire logic [`FRC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // forced-reset events
   input wire logic nmi_event,
   input wire logic watchdog_event
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   // clean_r: no register write since reset or nmi, so reset values must show
   logic clean_r;
   logic clean_nxt;
   logic reg_rd;
   logic [31:0] spare_mask;
   always_comb begin
      reg_rd = avs_read && !avs_waitrequest && !avs_address[`FRC_FLASH_SEL_BIT];
      spare_mask = 32'hFFFF_FFFF;
      if (avs_address == `FRC_REG_A_ADDR) spare_mask = 32'hFFFF_FF38;
      if (avs_address == `FRC_REG_B_ADDR) spare_mask = 32'hFFFF_FFBD;
      clean_nxt = clean_r;
      if (avs_write && !avs_waitrequest && !avs_address[`FRC_FLASH_SEL_BIT]) clean_nxt = 1'b0;
      if (rst || nmi_event) clean_nxt = 1'b1;
   end
   always_ff @(posedge clk) begin
      clean_r <= clean_nxt;
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_pending;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest;
   endsequence
   a_answer_bounded: assert property (s_pending |-> ##[1:64] s_answer)
      else $error("request not answered in time");
   a_wait_one_cycle: assert property (s_answer |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_answer_has_request: assert property (s_answer |-> $past(avs_read || avs_write))
      else $error("answer without a request");
   a_release_idle: assert property ($fell(rst) |-> avs_waitrequest && avs_readdata == 32'h0000_0000)
      else $error("bus not idle after reset");
   a_read_data_hold: assert property ((avs_waitrequest || avs_write) |-> $stable(avs_readdata))
      else $error("read data moved outside a read answer");
   a_spare_bits_zero: assert property (reg_rd |-> (avs_readdata & spare_mask) == 32'h0000_0000)
      else $error("spare or unmapped register bits not zero");
   a_reset_value_a: assert property (reg_rd && clean_r && avs_address == `FRC_REG_A_ADDR
      |-> avs_readdata == {24'h00_0000, `FRC_REG_A_RESET})
      else $error("control register a not at reset value");
   a_reset_value_b: assert property (reg_rd && clean_r && avs_address == `FRC_REG_B_ADDR
      |-> avs_readdata == {24'h00_0000, `FRC_REG_B_RESET})
      else $error("control register b not at reset value");
   a_flash_low_lanes: assert property (avs_read && !avs_waitrequest && avs_address[`FRC_FLASH_SEL_BIT]
      |-> avs_readdata[31:16] == 16'h0000)
      else $error("flash read upper lanes not zero");
endmodule : frc_sequencer_properties

// file: sim/frc_cpu_model.sv
// frc_cpu_model: on-chip cpu as avalon-mm master issuing register and flash word accesses
// assumes: xfer is called just after a rising edge of clk
`timescale 1ns/1ps
`include "frc_map.svh"
module frc_cpu_model (
   // clock
   input wire logic clk,
   // avalon-mm master side
   output logic [`FRC_ADDR_W-1:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [3:0] avs_byteenable,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 12'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'h1;
      avs_writedata = 32'h0000_0000;
   end
   // one word transfer; addresses are always word aligned, so even
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // released data must not keep looking valid
      avs_writedata <= ~d;
      @(posedge clk);
   endtask : xfer
endmodule : frc_cpu_model

// file: sim/tb_top.sv
// tb_top: self-checking bench for frc_sequencer against an integer model of the flash
// assumes: short operation counts; the cpu model owns the register bus
`timescale 1ns/1ps
`include "frc_map.svh"
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic nmi_event = 1'b0;
   logic watchdog_event = 1'b0;
   logic [`FRC_ADDR_W-1:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [15:0] dw;
   int bad_count = 0;
   int checks_done = 0;
   int mem[64];
   int pend = 0;
   bit lk[4];
   bit pe, ee, stm, lst, rwe, lkd;
   always #2.5 clk = ~clk;
   frc_sequencer #(.PROG_CYCLES(8), .ERASE_CYCLES(12), .LOCK_CYCLES(6), .RLS_CYCLES(6)) i_dut (
      .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .nmi_event(nmi_event), .watchdog_event(watchdog_event));
   frc_cpu_model i_cpu (
      .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   // ----------------------------------------
   // compare and model tasks
   // ----------------------------------------
   task automatic report(string what, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : report
   function automatic logic [31:0] reg_a(bit rdy);
      return {24'h00_0000, ee, pe, 3'b000, lkd, rwe, rdy};
   endfunction : reg_a
   task automatic chk_reg(logic [11:0] a, logic [31:0] e);
      i_cpu.xfer(1'b0, a, 32'h0000_0000, q);
      report("register", e, q);
   endtask : chk_reg
   task automatic chk_fl(int k);
      logic [31:0] e;
      e = stm ? {24'h00_0000, 2'b10, ee, pe, 4'h0} : 32'(mem[k]);
      i_cpu.xfer(1'b0, 12'h800 + 12'(4 * k), 32'h0000_0000, q);
      report("flash word", e, {16'h0000, q[15:0]});
   endtask : chk_fl
   task automatic wreg(logic [11:0] a, logic [7:0] d);
      i_cpu.xfer(1'b1, a, {24'h00_0000, d}, q);
      if (a == `FRC_REG_A_ADDR) begin
         rwe = d[1];
         lkd = d[2];
      end
   endtask : wreg
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         i_cpu.xfer(1'b0, `FRC_REG_A_ADDR, 32'h0000_0000, q);
         n++;
      end while (q[0] !== 1'b1 && n < 100);
      chk_reg(`FRC_REG_A_ADDR, reg_a(1'b1));
   endtask : wait_rdy
   // flash word write plus model update; command upper bytes are random
   task automatic fw(int k, logic [15:0] d);
      bit busy;
      bit prot;
      int b;
      logic [31:0] eb;
      // flags only change when the operation ends, so the busy view keeps the old ones
      eb = reg_a(1'b0);
      b = k / 16;
      busy = 0;
      prot = lk[b] && !lkd;
      if (pend != 'h40) d[15:8] = 8'($urandom);
      i_cpu.xfer(1'b1, 12'h800 + 12'(4 * k), {16'h0000, d}, q);
      if (pend == 'h40) begin
         pe = prot || ((mem[k] & d) != d);
         if (!prot) mem[k] = mem[k] & d;
         stm = 1;
         busy = 1;
      end else if (pend != 0) begin
         if (d[7:0] == 8'hFF) stm = 0;
         else if (d[7:0] != 8'hD0 || k % 16 != 15) begin
            if (pend != 'h71) begin pe = 1; ee = 1; end
         end else begin
            busy = 1;
            if (pend == 'h20) begin
               ee = prot;
               if (!prot) begin
                  lk[b] = 0;
                  for (int i = 0; i < 16; i++) mem[b * 16 + i] = 'hFFFF;
               end
               stm = 1;
            end
            if (pend == 'h77) begin lk[b] = 1; stm = 1; end
            if (pend == 'h71) lst = !lk[b];
         end
      end else begin
         case (d[7:0])
            8'hFF: stm = 0;
            8'h70: stm = 1;
            8'h50: begin pe = 0; ee = 0; end
            8'h71: begin pend = 'h71; stm = 0; end
            8'h40, 8'h20, 8'h77: if (!pe && !ee) pend = d[7:0];
            default: ;
         endcase
         busy = 0;
      end
      if (busy || (pend != 0 && !(d[7:0] inside {8'h40, 8'h20, 8'h77, 8'h71}))) pend = 0;
      if (busy) chk_reg(`FRC_REG_A_ADDR, eb);
      if (busy) wait_rdy();
   endtask : fw
   task automatic summarize();
      if (bad_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h3fcd));
      for (int i = 0; i < 64; i++) mem[i] = 'hFFFF;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_reg(`FRC_REG_A_ADDR, 32'h0000_0001);
      chk_reg(`FRC_REG_B_ADDR, 32'h0000_0000);
      wreg(12'h008, 8'hFF);
      chk_reg(12'h008, 32'h0000_0000);
      wreg(`FRC_REG_A_ADDR, 8'h00);
      wreg(`FRC_REG_A_ADDR, 8'h02);
      chk_reg(`FRC_REG_A_ADDR, reg_a(1'b1));
      chk_fl(3);
      dw = 16'($urandom) & 16'hFFFE;
      fw(5, 16'h0040);
      fw(5, dw);
      chk_fl(5);
      fw(5, 16'h00FF);
      chk_fl(5);
      fw(5, 16'h0040);
      fw(5, dw | 16'h0001);
      fw(6, 16'h0040);
      chk_reg(`FRC_REG_A_ADDR, reg_a(1'b1));
      fw(6, 16'h0070);
      chk_fl(6);
      fw(6, 16'h0050);
      chk_fl(6);
      for (int i = 0; i < 2; i++) begin
         fw(15, i ? 16'h0077 : 16'h0020);
         fw(15, 16'h0055);
         chk_reg(`FRC_REG_A_ADDR, reg_a(1'b1));
         fw(15, 16'h0050);
      end
      fw(15, 16'h0020);
      fw(15, 16'h00FF);
      chk_fl(5);
      fw(15, 16'h0020);
      fw(15, 16'h00D0);
      chk_fl(5);
      fw(0, 16'h00FF);
      chk_fl(5);
      fw(31, 16'h0077);
      fw(31, 16'h00D0);
      fw(31, 16'h0071);
      fw(31, 16'h00D0);
      chk_reg(`FRC_REG_B_ADDR, {25'h0, lst, 6'h00});
      fw(20, 16'h0040);
      fw(20, 16'h1234);
      fw(20, 16'h0050);
      fw(31, 16'h0020);
      fw(31, 16'h00D0);
      fw(31, 16'h0050);
      wreg(`FRC_REG_A_ADDR, 8'h02);
      wreg(`FRC_REG_A_ADDR, 8'h06);
      fw(31, 16'h0020);
      fw(31, 16'h00D0);
      fw(31, 16'h0071);
      fw(31, 16'h00D0);
      chk_reg(`FRC_REG_B_ADDR, {25'h0, lst, 6'h00});
      fw(31, 16'h00FF);
      chk_fl(20);
      for (int e = 0; e < 2; e++) begin
         wreg(`FRC_REG_A_ADDR, 8'h00);
         wreg(`FRC_REG_A_ADDR, 8'h02);
         fw(63, 16'h0020);
         i_cpu.xfer(1'b1, 12'hAFC, 32'h0000_00D0, q);
         if (e == 0) nmi_event <= 1'b1;
         else watchdog_event <= 1'b1;
         @(posedge clk);
         nmi_event <= 1'b0;
         watchdog_event <= 1'b0;
         {rwe, lkd, pe, ee, lst, stm} = 6'b00_0000;
         pend = 0;
         chk_reg(`FRC_REG_A_ADDR, reg_a(1'b1));
         chk_reg(`FRC_REG_B_ADDR, 32'h0000_0000);
         chk_fl(5);
      end
      // halting mode: no status read is issued here, and the watchdog must not reset
      wreg(`FRC_REG_B_ADDR, 8'h02);
      watchdog_event <= 1'b1;
      @(posedge clk);
      watchdog_event <= 1'b0;
      chk_reg(`FRC_REG_B_ADDR, 32'h0000_0002);
      summarize();
   end
endmodule : tb_top
bind frc_sequencer frc_sequencer_properties i_props (
   .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .nmi_event(nmi_event), .watchdog_event(watchdog_event));
